// [hdl/imd_data_space.sv]
/*
  Internal data memory and special function register space of an 8-bit
  controller core: 256 bytes of RAM, the register file in the upper half
  of the direct space, bank-relative working registers, bit access and
  stack push/pop.
  Assumes a single core clock, and that the execution logic issues at most
  one write-type request per cycle; simultaneous writes are resolved by a
  fixed priority. Read data returns one cycle after the request.
*/
`timescale 1ns/1ps

// How it works
// - One-byte address, 256-byte internal data space
// - Upper half registers reached only directly
// - Indirect upper half hits separate RAM
// - Lower half shared by direct and indirect
// - Lowest 32 bytes: four banks, eight registers
// - Status word bits pick the active bank
// - Bank select 0..3 gives base 00/08/10/18
// - Bytes 20..2F bit-addressable as bits 00..7F
// - Missing registers read zero, writes ignored
// - Registers at multiples of eight are bit-addressable
// - Registers take tabulated values on reset
// - Stack pointer increments before each push
// - Baud control keeps only its top bit
// - Page register gives high byte for register-indirect move
// - Accumulator holds the common operand
// - Aux register at F0 free for software
// - Two 16-bit pointers, select register at 92
// - Select bit 0 picks first or second pointer
module imd_data_space
  import imd_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // Direct byte access
  input  wire logic        i_dir_rd,
  input  wire logic        i_dir_wr,
  input  wire logic [7:0]  i_dir_addr,
  input  wire logic [7:0]  i_dir_wdata,
  output logic      [7:0]  o_dir_rdata,
  output logic             o_dir_valid,
  // Indirect byte access
  input  wire logic        i_ind_rd,
  input  wire logic        i_ind_wr,
  input  wire logic [7:0]  i_ind_addr,
  input  wire logic [7:0]  i_ind_wdata,
  output logic      [7:0]  o_ind_rdata,
  output logic             o_ind_valid,
  // Working register access in the active bank
  input  wire logic        i_reg_rd,
  input  wire logic        i_reg_wr,
  input  wire logic [2:0]  i_reg_num,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_reg_valid,
  // Bit access
  input  wire logic        i_bit_rd,
  input  wire logic        i_bit_wr,
  input  wire logic [7:0]  i_bit_addr,
  input  wire logic        i_bit_wdata,
  output logic             o_bit_rdata,
  output logic             o_bit_valid,
  // Stack
  input  wire logic        i_push,
  input  wire logic [7:0]  i_push_data,
  input  wire logic        i_pop,
  output logic      [7:0]  o_pop_data,
  output logic             o_pop_valid,
  // External data move addressing
  input  wire logic        i_ri_sel,
  output logic      [15:0] o_external_data_move_page_addr,
  output logic      [15:0] o_data_pointer_active,
  output logic      [2:0]  o_external_data_move_stretch,
  // Core state views
  output logic      [7:0]  o_accumulator,
  output logic      [7:0]  o_mul_div_aux,
  output logic      [7:0]  o_program_status_word,
  output logic      [7:0]  o_stack_pointer,
  output logic             o_baud_double
);

  logic [7:0] ram_reg [RAM_BYTES];
  logic [7:0] sfr_reg [SFR_COUNT];

  // Single arbitrated write into each store
  logic       ram_we;
  logic [7:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic       sfr_we;
  logic [6:0] sfr_widx;
  logic [7:0] sfr_wdata;

  logic [1:0] bank_sel;
  logic [7:0] reg_addr;
  logic [7:0] ri_addr;
  logic [7:0] sp_cur;
  logic [7:0] sp_inc;
  logic [7:0] sp_dec;
  logic [7:0] psw_view;
  logic [7:0] bit_byte_addr;
  logic [7:0] bit_byte;
  logic [7:0] bit_byte_new;
  logic [7:0] dir_byte;

  // Register read with hardware-owned bits merged in
  function automatic logic [7:0] sfr_read(input logic [6:0] idx);
    logic [7:0] a;
    a = {1'b1, idx};
    if (a == ADDR_PROGRAM_STATUS) begin
      sfr_read = {sfr_reg[idx][7:1], ^sfr_reg[ADDR_ACCUMULATOR[6:0]]};
    end else begin
      sfr_read = sfr_reg[idx];
    end
  endfunction

  assign bank_sel = {sfr_reg[ADDR_PROGRAM_STATUS[6:0]][PSW_BANK_HIGH_POS],
                     sfr_reg[ADDR_PROGRAM_STATUS[6:0]][PSW_BANK_LOW_POS]};
  assign reg_addr = {3'b000, bank_sel, i_reg_num};
  assign ri_addr  = {3'b000, bank_sel, 2'b00, i_ri_sel};
  assign sp_cur   = sfr_reg[ADDR_STACK_POINTER[6:0]];
  assign sp_inc   = sp_cur + 8'h01;
  assign sp_dec   = sp_cur - 8'h01;

  // Procedural so the views follow register contents, not only the address;
  // a continuous assign would wake on the function's arguments alone
  always_comb begin
    psw_view = sfr_read(ADDR_PROGRAM_STATUS[6:0]);
  end

  // Direct reads above 7F go to registers, below to shared RAM
  always_comb begin
    if (i_dir_addr[7]) begin
      dir_byte = sfr_read(i_dir_addr[6:0]);
    end else begin
      dir_byte = ram_reg[i_dir_addr];
    end
  end

  // Bit address to byte address and lane
  always_comb begin
    if (i_bit_addr < BIT_SFR_LIMIT) begin
      bit_byte_addr = BITAREA_BASE + {4'h0, i_bit_addr[6:3]};
      bit_byte      = ram_reg[bit_byte_addr];
    end else begin
      bit_byte_addr = {i_bit_addr[7:3], 3'b000};
      bit_byte      = sfr_read(bit_byte_addr[6:0]);
    end
    bit_byte_new                  = bit_byte;
    bit_byte_new[i_bit_addr[2:0]] = i_bit_wdata;
  end

  // Write arbitration: push, pop, direct, indirect, working register, bit
  always_comb begin
    ram_we    = 1'b0;
    ram_waddr = 8'h00;
    ram_wdata = 8'h00;
    sfr_we    = 1'b0;
    sfr_widx  = 7'h00;
    sfr_wdata = 8'h00;
    if (i_push) begin
      ram_we    = 1'b1;
      ram_waddr = sp_inc;
      ram_wdata = i_push_data;
      sfr_we    = 1'b1;
      sfr_widx  = ADDR_STACK_POINTER[6:0];
      sfr_wdata = sp_inc;
    end else if (i_pop) begin
      sfr_we    = 1'b1;
      sfr_widx  = ADDR_STACK_POINTER[6:0];
      sfr_wdata = sp_dec;
    end else if (i_dir_wr) begin
      if (i_dir_addr[7]) begin
        sfr_we    = 1'b1;
        sfr_widx  = i_dir_addr[6:0];
        sfr_wdata = i_dir_wdata;
      end else begin
        ram_we    = 1'b1;
        ram_waddr = i_dir_addr;
        ram_wdata = i_dir_wdata;
      end
    end else if (i_ind_wr) begin
      ram_we    = 1'b1;
      ram_waddr = i_ind_addr;
      ram_wdata = i_ind_wdata;
    end else if (i_reg_wr) begin
      ram_we    = 1'b1;
      ram_waddr = reg_addr;
      ram_wdata = i_reg_wdata;
    end else if (i_bit_wr) begin
      if (i_bit_addr < BIT_SFR_LIMIT) begin
        ram_we    = 1'b1;
        ram_waddr = bit_byte_addr;
        ram_wdata = bit_byte_new;
      end else begin
        sfr_we    = 1'b1;
        sfr_widx  = bit_byte_addr[6:0];
        sfr_wdata = bit_byte_new;
      end
    end
  end

  // RAM: one flop byte per address; upper half only reachable indirectly
  for (genvar g = 0; g < RAM_BYTES; g++) begin : g_ram
    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        ram_reg[g] <= RST_ZERO;
      end else if (ram_we && ram_waddr == 8'(g)) begin
        ram_reg[g] <= ram_wdata;
      end
    end
  end

  // Registers: absent addresses hold no flops, read zero, drop writes
  for (genvar g = 0; g < SFR_COUNT; g++) begin : g_sfr
    localparam logic [7:0] SFR_ADDR = 8'(g + 128);
    if (sfr_present(SFR_ADDR)) begin : g_present
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          sfr_reg[g] <= sfr_reset(SFR_ADDR);
        end else if (sfr_we && sfr_widx == 7'(g)) begin
          // Dead baud bits and the parity bit never store
          sfr_reg[g] <= sfr_wdata & sfr_wmask(SFR_ADDR);
        end
      end
    end else begin : g_absent
      assign sfr_reg[g] = RST_ZERO;
    end
  end

  // Read returns, one cycle after the request; data holds until next read
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_dir_rdata <= 8'h00;
      o_dir_valid <= 1'b0;
    end else begin
      o_dir_valid <= i_dir_rd;
      if (i_dir_rd) begin
        o_dir_rdata <= dir_byte;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ind_rdata <= 8'h00;
      o_ind_valid <= 1'b0;
    end else begin
      o_ind_valid <= i_ind_rd;
      if (i_ind_rd) begin
        o_ind_rdata <= ram_reg[i_ind_addr];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata <= 8'h00;
      o_reg_valid <= 1'b0;
    end else begin
      o_reg_valid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= ram_reg[reg_addr];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_bit_rdata <= 1'b0;
      o_bit_valid <= 1'b0;
    end else begin
      o_bit_valid <= i_bit_rd;
      if (i_bit_rd) begin
        o_bit_rdata <= bit_byte[i_bit_addr[2:0]];
      end
    end
  end

  // Pop reads at the old pointer, then the pointer steps down
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pop_data  <= 8'h00;
      o_pop_valid <= 1'b0;
    end else begin
      o_pop_valid <= i_pop && !i_push;
      if (i_pop && !i_push) begin
        o_pop_data <= ram_reg[sp_cur];
      end
    end
  end

  // State views lag the registers by one cycle so every output is a flop
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_external_data_move_page_addr      <= 16'h0000;
      o_data_pointer_active <= 16'h0000;
      o_external_data_move_stretch        <= 3'h0;
    end else begin
      o_external_data_move_page_addr <= {sfr_reg[ADDR_EXTERNAL_DATA_MOVE_PAGE_HIGH[6:0]], ram_reg[ri_addr]};
      if (sfr_reg[ADDR_POINTER_SELECT[6:0]][0]) begin
        o_data_pointer_active <= {sfr_reg[ADDR_DATA_POINTER1_HIGH[6:0]],
                                  sfr_reg[ADDR_DATA_POINTER1_LOW[6:0]]};
      end else begin
        o_data_pointer_active <= {sfr_reg[ADDR_DATA_POINTER0_HIGH[6:0]],
                                  sfr_reg[ADDR_DATA_POINTER0_LOW[6:0]]};
      end
      o_external_data_move_stretch <= sfr_reg[ADDR_EXTERNAL_DATA_MOVE_STRETCH_CTRL[6:0]][2:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_accumulator         <= RST_ZERO;
      o_mul_div_aux         <= RST_ZERO;
      o_program_status_word <= RST_ZERO;
      o_stack_pointer       <= RST_STACK_POINTER;
      o_baud_double         <= 1'b0;
    end else begin
      o_accumulator         <= sfr_reg[ADDR_ACCUMULATOR[6:0]];
      o_mul_div_aux         <= sfr_reg[ADDR_MUL_DIV_AUX[6:0]];
      o_program_status_word <= psw_view;
      o_stack_pointer       <= sp_cur;
      o_baud_double         <= sfr_reg[ADDR_BAUD_RATE_CONTROL[6:0]][7];
    end
  end

endmodule

// [hdl/imd_pkg.sv]
/*
  Constants for the internal data memory and special function register
  space of an 8-bit controller core: register addresses, reset values,
  write masks and the map of which register addresses exist.
  Assumes it is compiled before any file that imports it.
*/
package imd_pkg;

  // Space layout
  localparam int unsigned RAM_BYTES      = 256;
  localparam int unsigned SFR_COUNT      = 128;
  localparam logic [7:0]  BITAREA_BASE   = 8'h20;
  localparam logic [7:0]  BIT_SFR_LIMIT  = 8'h80;

  // Program status word fields
  localparam int unsigned PSW_PARITY_POS    = 0;
  localparam int unsigned PSW_BANK_LOW_POS  = 3;
  localparam int unsigned PSW_BANK_HIGH_POS = 4;

  // Register addresses
  localparam logic [7:0] ADDR_PORT0_LATCH        = 8'h80;
  localparam logic [7:0] ADDR_STACK_POINTER      = 8'h81;
  localparam logic [7:0] ADDR_DATA_POINTER0_LOW  = 8'h82;
  localparam logic [7:0] ADDR_DATA_POINTER0_HIGH = 8'h83;
  localparam logic [7:0] ADDR_DATA_POINTER1_LOW  = 8'h84;
  localparam logic [7:0] ADDR_DATA_POINTER1_HIGH = 8'h85;
  localparam logic [7:0] ADDR_WATCHDOG_RELOAD    = 8'h86;
  localparam logic [7:0] ADDR_UART_SPEED_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_TIMER_CONTROL      = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE_SELECT  = 8'h89;
  localparam logic [7:0] ADDR_TIMER0_COUNT_LOW   = 8'h8A;
  localparam logic [7:0] ADDR_TIMER1_COUNT_LOW   = 8'h8B;
  localparam logic [7:0] ADDR_TIMER0_COUNT_HIGH  = 8'h8C;
  localparam logic [7:0] ADDR_TIMER1_COUNT_HIGH  = 8'h8D;
  localparam logic [7:0] ADDR_EXTERNAL_DATA_MOVE_STRETCH_CTRL  = 8'h8E;
  localparam logic [7:0] ADDR_PORT1_LATCH        = 8'h90;
  localparam logic [7:0] ADDR_POINTER_SELECT     = 8'h92;
  localparam logic [7:0] ADDR_SERIAL0_CONTROL    = 8'h98;
  localparam logic [7:0] ADDR_SERIAL0_BUFFER     = 8'h99;
  localparam logic [7:0] ADDR_INT_ENABLE_2       = 8'h9A;
  localparam logic [7:0] ADDR_SERIAL1_CONTROL    = 8'h9B;
  localparam logic [7:0] ADDR_SERIAL1_BUFFER     = 8'h9C;
  localparam logic [7:0] ADDR_SERIAL1_RELOAD_LOW = 8'h9D;
  localparam logic [7:0] ADDR_PORT2_LATCH        = 8'hA0;
  localparam logic [7:0] ADDR_INT_ENABLE_0       = 8'hA8;
  localparam logic [7:0] ADDR_INT_PRIORITY_0     = 8'hA9;
  localparam logic [7:0] ADDR_SERIAL0_RELOAD_LOW = 8'hAA;
  localparam logic [7:0] ADDR_PORT3_LATCH        = 8'hB0;
  localparam logic [7:0] ADDR_INT_ENABLE_1       = 8'hB8;
  localparam logic [7:0] ADDR_INT_PRIORITY_1     = 8'hB9;
  localparam logic [7:0] ADDR_SERIAL0_RELOAD_HI  = 8'hBA;
  localparam logic [7:0] ADDR_SERIAL1_RELOAD_HI  = 8'hBB;
  localparam logic [7:0] ADDR_EXTERNAL_DATA_MOVE_PAGE_HIGH     = 8'hBF;
  localparam logic [7:0] ADDR_INT_REQUEST_FLAGS  = 8'hC0;
  localparam logic [7:0] ADDR_PROGRAM_STATUS     = 8'hD0;
  localparam logic [7:0] ADDR_BAUD_RATE_CONTROL  = 8'hD8;
  localparam logic [7:0] ADDR_ACCUMULATOR        = 8'hE0;
  localparam logic [7:0] ADDR_MUL_DIV_AUX        = 8'hF0;

  // Reset values; RST_ZERO and RST_PORT2_LATCH are zero
  localparam logic [7:0] RST_PORT_LATCH          = 8'hFF;
  localparam logic [7:0] RST_STACK_POINTER       = 8'h07;
  localparam logic [7:0] RST_EXTERNAL_DATA_MOVE_STRETCH        = 8'h01;
  localparam logic [7:0] RST_SERIAL0_RELOAD_LOW  = 8'hD9;
  localparam logic [7:0] RST_RELOAD_HIGH         = 8'h03;
  localparam logic [7:0] RST_ZERO                = 8'h00;
  localparam logic [7:0] RST_PORT2_LATCH         = 8'h00;

  // Write masks for registers with dead or hardware-owned bits
  localparam logic [7:0] WMASK_FULL              = 8'hFF;
  localparam logic [7:0] WMASK_PROGRAM_STATUS    = 8'hFE;
  localparam logic [7:0] WMASK_BAUD_RATE_CONTROL = 8'h80;

  function automatic logic sfr_present(input logic [7:0] a);
    case (a)
      ADDR_PORT0_LATCH, ADDR_STACK_POINTER, ADDR_DATA_POINTER0_LOW,
      ADDR_DATA_POINTER0_HIGH, ADDR_DATA_POINTER1_LOW, ADDR_DATA_POINTER1_HIGH,
      ADDR_WATCHDOG_RELOAD, ADDR_UART_SPEED_CONTROL, ADDR_TIMER_CONTROL,
      ADDR_TIMER_MODE_SELECT, ADDR_TIMER0_COUNT_LOW, ADDR_TIMER1_COUNT_LOW,
      ADDR_TIMER0_COUNT_HIGH, ADDR_TIMER1_COUNT_HIGH, ADDR_EXTERNAL_DATA_MOVE_STRETCH_CTRL,
      ADDR_PORT1_LATCH, ADDR_POINTER_SELECT, ADDR_SERIAL0_CONTROL,
      ADDR_SERIAL0_BUFFER, ADDR_INT_ENABLE_2, ADDR_SERIAL1_CONTROL,
      ADDR_SERIAL1_BUFFER, ADDR_SERIAL1_RELOAD_LOW, ADDR_PORT2_LATCH,
      ADDR_INT_ENABLE_0, ADDR_INT_PRIORITY_0, ADDR_SERIAL0_RELOAD_LOW,
      ADDR_PORT3_LATCH, ADDR_INT_ENABLE_1, ADDR_INT_PRIORITY_1,
      ADDR_SERIAL0_RELOAD_HI, ADDR_SERIAL1_RELOAD_HI, ADDR_EXTERNAL_DATA_MOVE_PAGE_HIGH,
      ADDR_INT_REQUEST_FLAGS, ADDR_PROGRAM_STATUS, ADDR_BAUD_RATE_CONTROL,
      ADDR_ACCUMULATOR, ADDR_MUL_DIV_AUX: sfr_present = 1'b1;
      default: sfr_present = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] sfr_reset(input logic [7:0] a);
    case (a)
      ADDR_PORT0_LATCH, ADDR_PORT1_LATCH,
      ADDR_PORT3_LATCH:        sfr_reset = RST_PORT_LATCH;
      ADDR_PORT2_LATCH:        sfr_reset = RST_PORT2_LATCH;
      ADDR_STACK_POINTER:      sfr_reset = RST_STACK_POINTER;
      ADDR_EXTERNAL_DATA_MOVE_STRETCH_CTRL:  sfr_reset = RST_EXTERNAL_DATA_MOVE_STRETCH;
      ADDR_SERIAL0_RELOAD_LOW: sfr_reset = RST_SERIAL0_RELOAD_LOW;
      ADDR_SERIAL0_RELOAD_HI,
      ADDR_SERIAL1_RELOAD_HI:  sfr_reset = RST_RELOAD_HIGH;
      default:                 sfr_reset = RST_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] sfr_wmask(input logic [7:0] a);
    case (a)
      ADDR_PROGRAM_STATUS:    sfr_wmask = WMASK_PROGRAM_STATUS;
      ADDR_BAUD_RATE_CONTROL: sfr_wmask = WMASK_BAUD_RATE_CONTROL;
      default:                sfr_wmask = WMASK_FULL;
    endcase
  endfunction

endpackage

// [tb/imd_core_model.sv]
/*
  Model of the core's execution logic: one request per call on the data
  space ports. Assumes callers run in the testbench's main sequence.
*/
`timescale 1ns/1ps
module imd_core_model (
  // Clock
  input  wire logic  i_clk,
  // Requests
  output logic       i_dir_rd, i_dir_wr, i_ind_rd, i_ind_wr, i_reg_rd, i_reg_wr,
  output logic       i_bit_rd, i_bit_wr, i_bit_wdata, i_push, i_pop,
  output logic [7:0] i_dir_addr, i_dir_wdata, i_ind_addr, i_ind_wdata,
  output logic [7:0] i_reg_wdata, i_bit_addr, i_push_data,
  output logic [2:0] i_reg_num
);
  initial begin
    {i_dir_rd, i_dir_wr, i_ind_rd, i_ind_wr, i_reg_rd, i_reg_wr} = '0;
    {i_bit_rd, i_bit_wr, i_bit_wdata, i_push, i_pop, i_reg_num} = '0;
    {i_dir_addr, i_dir_wdata, i_ind_addr, i_ind_wdata} = '0;
    {i_reg_wdata, i_bit_addr, i_push_data} = '0;
  end

  // Each signal is assigned once per call, so back-to-back calls never
  // give a strobe two values in one time step
  task automatic issue(input int k, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    {i_dir_rd, i_dir_wr, i_ind_rd, i_ind_wr} <= {k == 0, k == 1, k == 2, k == 3};
    {i_reg_rd, i_reg_wr, i_bit_rd, i_bit_wr} <= {k == 4, k == 5, k == 6, k == 7};
    {i_push, i_pop} <= {k == 8, k == 9};
    {i_dir_addr, i_ind_addr, i_bit_addr, i_reg_num} <= {a, a, a, a[2:0]};
    {i_dir_wdata, i_ind_wdata, i_reg_wdata, i_push_data} <= {d, d, d, d};
    i_bit_wdata <= d[0];
  endtask
endmodule

// [tb/imd_data_space_sva.sv]
/*
  Checker for the internal data space: read answer timing, indirect RAM
  write-through, stack step and register views.
  Assumes it is bound to imd_data_space and sees only its ports.
*/
`timescale 1ns/1ps
module imd_data_space_chk
  import imd_pkg::*;
(
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  // Requests
  input wire logic       i_dir_rd,
  input wire logic       i_dir_wr,
  input wire logic [7:0] i_dir_addr,
  input wire logic [7:0] i_dir_wdata,
  input wire logic       i_ind_rd,
  input wire logic       i_ind_wr,
  input wire logic [7:0] i_ind_addr,
  input wire logic [7:0] i_ind_wdata,
  input wire logic       i_push,
  input wire logic       i_pop,
  // Answers and views
  input wire logic       o_dir_valid,
  input wire logic [7:0] o_ind_rdata,
  input wire logic [7:0] o_stack_pointer,
  input wire logic       o_baud_double,
  input wire logic [7:0] o_mul_div_aux,
  input wire logic [7:0] o_accumulator,
  input wire logic [2:0] o_external_data_move_stretch
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // Without a stack operation a direct byte write is never preempted
  sequence s_still;
    !i_push && !i_pop;
  endsequence
  sequence s_dir_store(logic [7:0] a);
    i_dir_wr && i_dir_addr == a && !i_push && !i_pop;
  endsequence

  property p_dir_answer;
    i_dir_rd |=> o_dir_valid;
  endproperty
  a_dir_answer: assert property (p_dir_answer)
    else $error("direct read not answered");
  property p_dir_quiet;
    !i_dir_rd |=> !o_dir_valid;
  endproperty
  a_dir_quiet: assert property (p_dir_quiet)
    else $error("direct valid without read");
  property p_ind_ram;
    (i_ind_wr && !i_dir_wr && !i_push && !i_pop ##1 i_ind_rd && i_ind_addr == $past(i_ind_addr))
      |=> o_ind_rdata == $past(i_ind_wdata, 2);
  endproperty
  a_ind_ram: assert property (p_ind_ram)
    else $error("indirect byte not read back");
  property p_push_step;
    s_still ##1 (i_push && !i_pop) ##1 s_still
      |=> o_stack_pointer == $past(o_stack_pointer, 2) + 8'h01;
  endproperty
  a_push_step: assert property (p_push_step)
    else $error("push did not step stack pointer by one");
  property p_reset_view;
    $rose(i_arst_n) |=> o_stack_pointer == RST_STACK_POINTER
      && o_external_data_move_stretch == RST_EXTERNAL_DATA_MOVE_STRETCH[2:0];
  endproperty
  a_reset_view: assert property (p_reset_view)
    else $error("views not at reset values");
  property p_baud;
    s_dir_store(ADDR_BAUD_RATE_CONTROL) |-> ##2 o_baud_double == $past(i_dir_wdata[7], 2);
  endproperty
  a_baud: assert property (p_baud)
    else $error("baud bit view wrong");
  property p_aux;
    s_dir_store(ADDR_MUL_DIV_AUX) |-> ##2 o_mul_div_aux == $past(i_dir_wdata, 2);
  endproperty
  a_aux: assert property (p_aux)
    else $error("aux view wrong");
  property p_acc;
    s_dir_store(ADDR_ACCUMULATOR) |-> ##2 o_accumulator == $past(i_dir_wdata, 2);
  endproperty
  a_acc: assert property (p_acc)
    else $error("accumulator view wrong");
endmodule

bind imd_data_space imd_data_space_chk imd_data_space_chk_i (.*);

// [tb/imd_data_space_tb.sv]
/*
  Self-checking testbench for the internal data space.
  Assumes imd_pkg, the core model and the bound checker are compiled.
*/
`timescale 1ns/1ps
module imd_data_space_tb
  import imd_pkg::*;
;
  localparam int DRD = 0, DWR = 1, IRD = 2, IWR = 3, RRD = 4, RWR = 5;
  localparam int BRD = 6, BWR = 7, PSH = 8, POP = 9, IDL = 15;
  logic        i_clk, i_arst_n, i_ri_sel;
  logic        i_dir_rd, i_dir_wr, i_ind_rd, i_ind_wr, i_reg_rd, i_reg_wr;
  logic        i_bit_rd, i_bit_wr, i_bit_wdata, i_push, i_pop;
  logic [7:0]  i_dir_addr, i_dir_wdata, i_ind_addr, i_ind_wdata;
  logic [7:0]  i_reg_wdata, i_bit_addr, i_push_data;
  logic [2:0]  i_reg_num, o_external_data_move_stretch;
  logic [7:0]  o_dir_rdata, o_ind_rdata, o_reg_rdata, o_pop_data, o_stack_pointer;
  logic        o_dir_valid, o_ind_valid, o_reg_valid, o_bit_valid, o_pop_valid;
  logic        o_bit_rdata, o_baud_double;
  logic [15:0] o_external_data_move_page_addr, o_data_pointer_active;
  logic [7:0]  o_accumulator, o_mul_div_aux, o_program_status_word;
  int          failures = 0;
  int          checked = 0;
  logic [15:0] rst_tab [38] = '{16'h80FF, 16'h8107, 16'h8200, 16'h8300, 16'h8400, 16'h8500,
    16'h8600, 16'h8700, 16'h8800, 16'h8900, 16'h8A00, 16'h8B00, 16'h8C00, 16'h8D00,
    16'h8E01, 16'h90FF, 16'h9200, 16'h9800, 16'h9900, 16'h9A00, 16'h9B00, 16'h9C00,
    16'h9D00, 16'hA000, 16'hA800, 16'hA900, 16'hAAD9, 16'hB0FF, 16'hB800, 16'hB900,
    16'hBA03, 16'hBB03, 16'hBF00, 16'hC000, 16'hD000, 16'hD800, 16'hE000, 16'hF000};

  imd_data_space imd_data_space_i (.*);
  imd_core_model imd_core_model_i (.*);

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic summarize();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic idle();
    imd_core_model_i.issue(IDL, 8'h00, 8'h00);
  endtask

  task automatic wr(input int k, input logic [7:0] a, input logic [7:0] d);
    imd_core_model_i.issue(k, a, d);
    imd_core_model_i.issue(IDL, ~a, ~d);
  endtask

  // Answer stands one cycle, so it is taken at the next falling edge
  task automatic rd(input int k, input logic [7:0] a, input logic [7:0] exp);
    logic [8:0] got;
    imd_core_model_i.issue(k, a, 8'h00);
    imd_core_model_i.issue(IDL, ~a, 8'h00);
    case (k)
      DRD: got = {o_dir_valid, o_dir_rdata};
      IRD: got = {o_ind_valid, o_ind_rdata};
      RRD: got = {o_reg_valid, o_reg_rdata};
      BRD: got = {o_bit_valid, 7'h00, o_bit_rdata};
      default: got = {o_pop_valid, o_pop_data};
    endcase
    check($sformatf("read %0d at %h", k, a), {7'h00, got}, {8'h01, exp});
  endtask

  task automatic do_reset();
    @(negedge i_clk);
    i_arst_n = 1'b0;
    repeat (2) @(negedge i_clk);
    i_arst_n = 1'b1;
    idle();
  endtask

  task automatic t_reset();
    check("stack view", {8'h00, o_stack_pointer}, 16'h0007);
    check("stretch view", {13'h0000, o_external_data_move_stretch}, 16'h0001);
    foreach (rst_tab[n]) rd(DRD, rst_tab[n][15:8], rst_tab[n][7:0]);
  endtask

  task automatic t_access();
    logic [7:0] e;
    foreach (rst_tab[n]) wr(DWR, rst_tab[n][15:8], ~rst_tab[n][7:0]);
    foreach (rst_tab[n]) begin
      e = ~rst_tab[n][7:0];
      if (rst_tab[n][15:8] == ADDR_BAUD_RATE_CONTROL) e = e & 8'h80;
      // Accumulator now holds FF, an even count of ones
      if (rst_tab[n][15:8] == ADDR_PROGRAM_STATUS) e[0] = 1'b0;
      rd(DRD, rst_tab[n][15:8], e);
    end
    do_reset();
    check("stack view", {8'h00, o_stack_pointer}, 16'h0007);
  endtask

  task automatic t_ram();
    wr(DWR, 8'hC8, 8'h5A);
    rd(DRD, 8'hC8, 8'h00);
    rd(IRD, 8'hC8, 8'h00);
    wr(DWR, ADDR_MUL_DIV_AUX, 8'h11);
    imd_core_model_i.issue(IWR, ADDR_MUL_DIV_AUX, 8'h22);
    rd(IRD, ADDR_MUL_DIV_AUX, 8'h22);
    rd(DRD, ADDR_MUL_DIV_AUX, 8'h11);
    check("aux view", {8'h00, o_mul_div_aux}, 16'h0011);
    wr(DWR, 8'h45, 8'h33);
    rd(IRD, 8'h45, 8'h33);
    wr(IWR, 8'h7F, 8'h44);
    rd(DRD, 8'h7F, 8'h44);
    wr(DWR, ADDR_ACCUMULATOR, 8'h07);
    idle();
    check("acc view", {o_program_status_word[0], o_accumulator}, 16'h0107);
  endtask

  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      wr(DWR, ADDR_PROGRAM_STATUS, 8'(b << 3));
      wr(RWR, 8'h07, 8'hB0 + 8'(b));
      rd(RRD, 8'h07, 8'hB0 + 8'(b));
    end
    for (int b = 0; b < 4; b++) rd(IRD, 8'(8 * b + 7), 8'hB0 + 8'(b));
    wr(RWR, 8'h01, 8'h3C);
    wr(DWR, ADDR_EXTERNAL_DATA_MOVE_PAGE_HIGH, 8'h5C);
    i_ri_sel = 1'b1;
    idle();
    idle();
    check("page address", o_external_data_move_page_addr, 16'h5C3C);
    // Bank 3 R0 at 18 was never written, so the low byte is zero
    i_ri_sel = 1'b0;
    idle();
    idle();
    check("page address", o_external_data_move_page_addr, 16'h5C00);
  endtask

  task automatic t_bits();
    wr(BWR, 8'h0A, 8'h01);
    rd(DRD, 8'h21, 8'h04);
    wr(BWR, 8'h7F, 8'h01);
    rd(IRD, 8'h2F, 8'h80);
    rd(BRD, 8'h0A, 8'h01);
    wr(BWR, 8'h8B, 8'h01);
    rd(DRD, ADDR_TIMER_CONTROL, 8'h08);
    wr(BWR, 8'hF7, 8'h01);
    rd(DRD, ADDR_MUL_DIV_AUX, 8'h91);
  endtask

  task automatic t_stack();
    do_reset();
    imd_core_model_i.issue(PSH, 8'h00, 8'hAA);
    wr(PSH, 8'h00, 8'hBB);
    idle();
    check("stack view", {8'h00, o_stack_pointer}, 16'h0009);
    rd(IRD, 8'h08, 8'hAA);
    rd(POP, 8'h00, 8'hBB);
    rd(POP, 8'h00, 8'hAA);
    wr(PSH, 8'h00, 8'hCC);
    rd(IRD, 8'h08, 8'hCC);
  endtask

  task automatic t_regs();
    wr(DWR, ADDR_DATA_POINTER0_LOW, 8'h34);
    wr(DWR, ADDR_DATA_POINTER0_HIGH, 8'h12);
    wr(DWR, ADDR_DATA_POINTER1_LOW, 8'h78);
    wr(DWR, ADDR_DATA_POINTER1_HIGH, 8'h56);
    check("pointer", o_data_pointer_active, 16'h1234);
    wr(DWR, ADDR_POINTER_SELECT, 8'h01);
    idle();
    check("pointer", o_data_pointer_active, 16'h5678);
    wr(DWR, ADDR_POINTER_SELECT, 8'hFE);
    idle();
    check("pointer", o_data_pointer_active, 16'h1234);
    wr(DWR, ADDR_BAUD_RATE_CONTROL, 8'h7F);
    rd(DRD, ADDR_BAUD_RATE_CONTROL, 8'h00);
    wr(DWR, ADDR_BAUD_RATE_CONTROL, 8'hFF);
    rd(DRD, ADDR_BAUD_RATE_CONTROL, 8'h80);
    check("baud", {15'h0000, o_baud_double}, 16'h0001);
    wr(DWR, ADDR_EXTERNAL_DATA_MOVE_STRETCH_CTRL, 8'h07);
    idle();
    check("stretch", {13'h0000, o_external_data_move_stretch}, 16'h0007);
  endtask

  initial begin
    i_arst_n = 1'b0;
    i_ri_sel = 1'b0;
    do_reset();
    t_reset();
    t_access();
    t_ram();
    t_banks();
    t_bits();
    t_stack();
    t_regs();
    summarize();
  end

  // The sequence needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge i_clk);
    failures++;
    summarize();
  end
endmodule
